// File: src/link_app_regs.sv
`timescale 1ns/1ps
module link_app_regs
	import link_app_regs_pkg::*;
(
	// Clock and reset
	input  wire logic                   ref_clk,
	input  wire logic                   sys_rst,
	// Network side register access
	input  wire reg_access_t            netAcc,
	output logic       [15:0]           netRdata,
	// Local host port register access
	input  wire reg_access_t            hostAcc,
	output logic       [15:0]           hostRdata,
	// Datagram address for combined read-write commands
	input  wire logic  [15:0]           dgramAddr,
	output logic       [15:0]           dgramRdAddr,
	output logic       [15:0]           dgramWrAddr,
	// Port pins, asynchronous
	input  wire port_info_t [NUM_PORTS-1:0] portPins,
	// Device status inputs, same clock
	input  wire logic                   cfgLoaded,
	input  wire logic                   hostPortOk,
	input  wire logic                   hostWdogReloaded,
	input  wire logic                   cfgEnhLink,
	input  wire logic                   cfgLoadStrobe,
	input  wire logic                   devEmulation,
	input  wire logic                   writeAckEn,
	// Outputs to the rest of the device
	output logic                        pdRamAccessEn,
	output logic       [NUM_PORTS-1:0]  loopClosed,
	output logic       [15:0]           reqState,
	output logic                        appEvtReq,
	output logic                        netEvtLinkStat,
	output logic                        netEvtAppStat,
	// Event sources for network flags
	input  wire logic                   linkChangeEvt,
	input  wire logic                   appStatChangeEvt
);
	logic [15:0]          rwOffset_reg;
	logic [15:0]          appReq_reg;
	logic [15:0]          appReport_reg;
	logic                 mboxLocked_reg;
	logic                 appEvt_reg;
	logic                 netEvtLink_reg;
	logic                 netEvtApp_reg;
	logic                 enhLink_reg;
	logic                 firstLoadDone_reg;
	logic [15:0]          netRdata_reg;
	logic [15:0]          hostRdata_reg;
	logic [15:0]          linkStatus;
	port_info_t [NUM_PORTS-1:0] portSync;

	function automatic logic hit(input reg_access_t acc, input logic [15:0] base);
		hit = (acc.addr[15:1] == base[15:1]) && (acc.byteEn != 2'b00);
	endfunction : hit

	// Pins cross into this domain before any decode
	sync2 #(.WIDTH(NUM_PORTS * $bits(port_info_t))) u_portSync
	(
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.asyncIn (portPins),
		.syncOut (portSync)
	);

	// Synchronised pins are meaningless until both flops have filled
	logic [1:0] syncFill_reg;
	logic       syncValid;

	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
			syncFill_reg <= 2'b00;
		else if (syncFill_reg != 2'b11)
			syncFill_reg <= syncFill_reg + 2'b01;
	end

	// Loops hold their reset state until the pins are trusted
	assign syncValid = (syncFill_reg == 2'b11);

	genvar p;
	generate
		for (p = 0; p < NUM_PORTS; p++)
		begin : g_port
			loop_port_gate u_gate
			(
				.ref_clk      (ref_clk),
				.sys_rst      (sys_rst),
				.loopCloseReq (portSync[p].loopCloseReq),
				.frameBusy    (portSync[p].frameBusy || !syncValid),
				.loopClosed   (loopClosed[p])
			);
			assign linkStatus[STAT_LINK_LSB + p]     = portSync[p].linkUp;
			assign linkStatus[STAT_PORT_LSB + 2 * p] = loopClosed[p];
			assign linkStatus[STAT_PORT_LSB + 2 * p + 1] = portSync[p].commOk;
		end
	endgenerate

	assign linkStatus[0]            = cfgLoaded && hostPortOk;
	assign linkStatus[1]            = hostWdogReloaded;
	assign linkStatus[STAT_ENH_BIT] = enhLink_reg;
	assign linkStatus[3]            = 1'b0;
	assign pdRamAccessEn            = linkStatus[0];

	// Enhanced link taken only at first load, later loads ignored
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			enhLink_reg       <= 1'b0;
			firstLoadDone_reg <= 1'b0;
		end
		else if (cfgLoadStrobe && !firstLoadDone_reg)
		begin
			enhLink_reg       <= cfgEnhLink;
			firstLoadDone_reg <= 1'b1;
		end
	end

	// Offset writable from network only
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
			rwOffset_reg <= RST_RW_OFFSET;
		else if (netAcc.wr && hit(netAcc, ADDR_RW_OFFSET))
		begin
			if (netAcc.byteEn[0])
				rwOffset_reg[7:0] <= netAcc.wdata[7:0];
			if (netAcc.byteEn[1])
				rwOffset_reg[15:8] <= netAcc.wdata[15:8];
		end
	end

	assign dgramRdAddr = dgramAddr;
	assign dgramWrAddr = dgramAddr + rwOffset_reg;

	logic netCtrlWr;
	logic netCtrlAccept;
	logic hostCtrlAck;
	logic hostCtrlRearm;
	assign netCtrlWr     = netAcc.wr && hit(netAcc, ADDR_APP_REQ);
	assign netCtrlAccept = netCtrlWr && (devEmulation || !mboxLocked_reg);
	// Any byte of either half re-arms
	assign hostCtrlRearm = hit(hostAcc, ADDR_APP_REQ) && (hostAcc.rd || (hostAcc.wr && writeAckEn));
	assign hostCtrlAck   = hit(hostAcc, ADDR_APP_REQ)
		&& (writeAckEn ? hostAcc.wr : hostAcc.rd);

	logic [15:0] appReq_next;

	// Byte lanes merged once so control and its mirror never disagree
	always_comb
	begin
		appReq_next = appReq_reg;
		if (netCtrlAccept)
		begin
			if (netAcc.byteEn[0])
				appReq_next[7:0] = netAcc.wdata[7:0] & APP_VALID_MASK[7:0];
			if (netAcc.byteEn[1])
				appReq_next[15:8] = netAcc.wdata[15:8] & APP_VALID_MASK[15:8];
		end
	end

	// Control register; host writes never change its value
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
			appReq_reg <= RST_APP_REQ;
		else
			appReq_reg <= appReq_next;
	end

	assign reqState = appReq_reg;

	// Unlocked after reset so the first write lands
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
			mboxLocked_reg <= 1'b0;
		else if (netCtrlAccept && !devEmulation)
			mboxLocked_reg <= 1'b1;
		else if (hostCtrlRearm)
			mboxLocked_reg <= 1'b0;
	end

	// Set wins over the acknowledge in the same cycle
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
			appEvt_reg <= 1'b0;
		else if (netCtrlAccept)
			appEvt_reg <= 1'b1;
		else if (hostCtrlAck)
			appEvt_reg <= 1'b0;
	end

	assign appEvtReq = appEvt_reg;

	// Status: host-owned unless emulation mirrors control
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
			appReport_reg <= RST_APP_REPORT;
		else if (devEmulation)
		begin
			if (netCtrlAccept)
				appReport_reg <= appReq_next;
		end
		else if (hostAcc.wr && hit(hostAcc, ADDR_APP_REPORT))
		begin
			if (hostAcc.byteEn[0])
				appReport_reg[7:0] <= hostAcc.wdata[7:0] & APP_VALID_MASK[7:0];
			if (hostAcc.byteEn[1])
				appReport_reg[15:8] <= hostAcc.wdata[15:8] & APP_VALID_MASK[15:8];
		end
	end

	// Network event flags: set wins over read clear
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
			netEvtLink_reg <= 1'b0;
		else if (linkChangeEvt)
			netEvtLink_reg <= 1'b1;
		else if (netAcc.rd && hit(netAcc, ADDR_LINK_STAT))
			netEvtLink_reg <= 1'b0;
	end

	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
			netEvtApp_reg <= 1'b0;
		else if (appStatChangeEvt)
			netEvtApp_reg <= 1'b1;
		else if (netAcc.rd && hit(netAcc, ADDR_APP_REPORT))
			netEvtApp_reg <= 1'b0;
	end

	assign netEvtLinkStat = netEvtLink_reg;
	assign netEvtAppStat  = netEvtApp_reg;

	function automatic logic [15:0] readMux(input reg_access_t acc, input logic [15:0] lstat,
		input logic [15:0] off, input logic [15:0] req, input logic [15:0] rep);
		if (hit(acc, ADDR_RW_OFFSET))
			readMux = off;
		else if (hit(acc, ADDR_LINK_STAT))
			readMux = lstat;
		else if (hit(acc, ADDR_APP_REQ))
			readMux = req;
		else if (hit(acc, ADDR_APP_REPORT))
			readMux = rep;
		else
			readMux = 16'h0000;
	endfunction : readMux

	// Read data registered one cycle after the strobe
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
			netRdata_reg <= 16'h0000;
		else if (netAcc.rd)
			netRdata_reg <= readMux(netAcc, linkStatus, rwOffset_reg, appReq_reg, appReport_reg);
	end

	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
			hostRdata_reg <= 16'h0000;
		else if (hostAcc.rd)
			hostRdata_reg <= readMux(hostAcc, linkStatus, rwOffset_reg, appReq_reg, appReport_reg);
	end

	assign netRdata  = netRdata_reg;
	assign hostRdata = hostRdata_reg;
endmodule : link_app_regs

// File: shared/link_app_regs_pkg.sv
package link_app_regs_pkg;
	localparam logic [15:0] ADDR_RW_OFFSET  = 16'h0108;
	localparam logic [15:0] ADDR_LINK_STAT  = 16'h0110;
	localparam logic [15:0] ADDR_APP_REQ    = 16'h0120;
	localparam logic [15:0] ADDR_APP_REPORT = 16'h0130;
	localparam logic [15:0] RST_RW_OFFSET   = 16'h0000;
	localparam logic [15:0] RST_APP_REQ     = 16'h0000;
	localparam logic [15:0] RST_APP_REPORT  = 16'h0001;
	localparam int          NUM_PORTS       = 4;
	localparam int          STAT_ENH_BIT    = 2;
	localparam int          STAT_LINK_LSB   = 4;
	localparam int          STAT_PORT_LSB   = 8;
	localparam int          APP_ERR_BIT     = 4;
	localparam int          APP_ID_BIT      = 5;
	localparam logic [15:0] APP_VALID_MASK  = 16'h003F;
	localparam int          NET_EVT_LINK    = 2;
	localparam int          NET_EVT_APP     = 3;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [15:0] addr;
		logic [15:0] wdata;
		logic [1:0]  byteEn;
	} reg_access_t;

	typedef struct packed {
		logic linkUp;
		logic commOk;
		logic frameBusy;
		logic loopCloseReq;
	} port_info_t;
endpackage : link_app_regs_pkg

// File: src/loop_port_gate.sv
`timescale 1ns/1ps
module loop_port_gate
	import link_app_regs_pkg::*;
(
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic sys_rst,
	// Port state, already synchronised
	input  wire logic loopCloseReq,
	input  wire logic frameBusy,
	// Applied loop state
	output logic      loopClosed
);
	logic loopClosed_reg;

	// Closed after reset so no frame leaks onto an unlinked port
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
			loopClosed_reg <= 1'b1;
		else if (!frameBusy)
			loopClosed_reg <= loopCloseReq;
	end

	assign loopClosed = loopClosed_reg;
endmodule : loop_port_gate

// File: src/sync2.sv
`timescale 1ns/1ps
module sync2
	#(parameter int WIDTH = 1)
(
	// Clock and reset
	input  wire logic             ref_clk,
	input  wire logic             sys_rst,
	// Asynchronous input and synchronised output
	input  wire logic [WIDTH-1:0] asyncIn,
	output logic      [WIDTH-1:0] syncOut
);
	logic [WIDTH-1:0] stage1_reg;
	logic [WIDTH-1:0] stage2_reg;

	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			stage1_reg <= '0;
			stage2_reg <= '0;
		end
		else
		begin
			stage1_reg <= asyncIn;
			stage2_reg <= stage1_reg;
		end
	end

	assign syncOut = stage2_reg;
endmodule : sync2

// File: tb/port_link_model.sv
`timescale 1ns/1ps
module port_link_model
	import link_app_regs_pkg::*;
	#(parameter int FRAME_CYCLES = 20)
(
	// Clock
	input  wire logic                  ref_clk,
	// Commanded state per port
	input  wire logic [NUM_PORTS-1:0]  linkSet,
	input  wire logic [NUM_PORTS-1:0]  loopSet,
	input  wire logic [NUM_PORTS-1:0]  frameStart,
	// Pins toward the device
	output port_info_t [NUM_PORTS-1:0] portPins
);
	int busyCnt [NUM_PORTS] = '{default: 0};

	// Frame length fixed; enough to outlast the pin synchronisers
	always @(posedge ref_clk)
		for (int i = 0; i < NUM_PORTS; i++)
		begin
			busyCnt[i] <= frameStart[i] ? FRAME_CYCLES : (busyCnt[i] > 0 ? busyCnt[i] - 1 : 0);
		end

	// Stable communication only where a link stands
	always_comb
		for (int i = 0; i < NUM_PORTS; i++)
		begin
			portPins[i] = '{linkSet[i], linkSet[i], busyCnt[i] > 0, loopSet[i]};
		end
endmodule : port_link_model

// File: tb/link_app_regs_monitor.sv
`timescale 1ns/1ps
module link_app_regs_monitor
	import link_app_regs_pkg::*;
(
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	// Accesses and inputs
	input  wire reg_access_t netAcc,
	input  wire reg_access_t hostAcc,
	input  wire logic [15:0] dgramAddr,
	input  wire logic        cfgLoaded,
	input  wire logic        hostPortOk,
	input  wire logic        devEmulation,
	input  wire logic        writeAckEn,
	input  wire logic        linkChangeEvt,
	input  wire logic        appStatChangeEvt,
	// Outputs watched
	input  wire logic [15:0] dgramRdAddr,
	input  wire logic        pdRamAccessEn,
	input  wire logic [15:0] reqState,
	input  wire logic        appEvtReq,
	input  wire logic        netEvtLinkStat,
	input  wire logic        netEvtAppStat
);
	function automatic logic hit(reg_access_t a, logic [15:0] b);
		return a.byteEn != 2'b00 && a.addr[15:1] == b[15:1];
	endfunction : hit

	logic netCtlWr;
	assign netCtlWr = netAcc.wr && hit(netAcc, ADDR_APP_REQ);

	// Mailbox lock rebuilt from the accesses, devEmulation and writeAckEn
	logic lockSeen_reg;

	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
			lockSeen_reg <= 1'b0;
		else if (netCtlWr && !devEmulation && !lockSeen_reg)
			lockSeen_reg <= 1'b1;
		else if (hit(hostAcc, ADDR_APP_REQ) && (hostAcc.rd || (hostAcc.wr && writeAckEn)))
			lockSeen_reg <= 1'b0;
	end

	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	dgram_rd_a: assert property (dgramRdAddr == dgramAddr)
		else $error("read address differs");
	pdram_gate_a: assert property (pdRamAccessEn == (cfgLoaded && hostPortOk))
		else $error("process data access gate wrong");
	link_evt_clr_a: assert property (netAcc.rd && hit(netAcc, ADDR_LINK_STAT) && !linkChangeEvt
		|=> !netEvtLinkStat) else $error("link event not cleared");
	app_evt_clr_a: assert property (netAcc.rd && hit(netAcc, ADDR_APP_REPORT) && !appStatChangeEvt
		|=> !netEvtAppStat) else $error("app event not cleared");
	ctl_accept_a: assert property (netCtlWr && netAcc.byteEn[0] && !appEvtReq
		|=> appEvtReq && reqState[3:0] == $past(netAcc.wdata[3:0])) else $error("write lost");
	ctl_lock_a: assert property (netCtlWr && lockSeen_reg && !devEmulation
		|=> $stable(reqState)) else $error("locked write taken");
	host_rd_clr_a: assert property (hostAcc.rd && hit(hostAcc, ADDR_APP_REQ) && !writeAckEn
		&& !netCtlWr |=> !appEvtReq) else $error("host read did not clear");
	host_wr_ack_a: assert property (hostAcc.wr && hit(hostAcc, ADDR_APP_REQ) && writeAckEn
		&& !netCtlWr |=> !appEvtReq && $stable(reqState)) else $error("host write ack wrong");
endmodule : link_app_regs_monitor

bind link_app_regs link_app_regs_monitor u_mon (.ref_clk, .sys_rst, .netAcc, .hostAcc,
	.dgramAddr, .cfgLoaded, .hostPortOk, .devEmulation, .writeAckEn, .linkChangeEvt,
	.appStatChangeEvt, .dgramRdAddr, .pdRamAccessEn, .reqState, .appEvtReq,
	.netEvtLinkStat, .netEvtAppStat);

// File: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import link_app_regs_pkg::*;
	logic                       ref_clk = 1'b0;
	logic                       sys_rst = 1'b1;
	reg_access_t                netAcc = '0;
	reg_access_t                hostAcc = '0;
	logic [15:0]                dgramAddr = 16'h0000;
	logic                       cfgLoaded = 1'b1, hostPortOk = 1'b1, hostWdogReloaded = 1'b1;
	logic                       cfgEnhLink = 1'b1, cfgLoadStrobe = 1'b0;
	logic                       devEmulation = 1'b0, writeAckEn = 1'b0;
	logic                       linkChangeEvt = 1'b0, appStatChangeEvt = 1'b0;
	logic [3:0]                 linkSet = 4'h8, loopSet = 4'hF, frameStart = 4'h0;
	port_info_t [NUM_PORTS-1:0] portPins;
	logic [15:0]                netRdata, hostRdata, dgramRdAddr, dgramWrAddr, reqState, q;
	logic [3:0]                 loopClosed;
	logic                       pdRamAccessEn, appEvtReq, netEvtLinkStat, netEvtAppStat;
	int                         error_cnt = 0, compares = 0;

	always #25 ref_clk = ~ref_clk;

	port_link_model u_phy (.ref_clk, .linkSet, .loopSet, .frameStart, .portPins);
	link_app_regs u_dut (.ref_clk, .sys_rst, .netAcc, .netRdata, .hostAcc, .hostRdata,
		.dgramAddr, .dgramRdAddr, .dgramWrAddr, .portPins, .cfgLoaded, .hostPortOk,
		.hostWdogReloaded, .cfgEnhLink, .cfgLoadStrobe, .devEmulation, .writeAckEn,
		.pdRamAccessEn, .loopClosed, .reqState, .appEvtReq, .netEvtLinkStat, .netEvtAppStat,
		.linkChangeEvt, .appStatChangeEvt);

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// One access, one cycle wide; read data taken one edge after it is registered
	task automatic op(input bit h, input bit wr, input logic [15:0] a, input logic [15:0] d);
		reg_access_t x;
		x = '{wr, !wr, a, d, 2'b11};
		@(posedge ref_clk);
		if (h)
			hostAcc <= x;
		else
			netAcc <= x;
		@(posedge ref_clk);
		hostAcc <= '0;
		netAcc <= '0;
		@(posedge ref_clk);
		q = h ? hostRdata : netRdata;
	endtask : op

	task automatic tally_and_finish;
		$display("errors=%0d compares=%0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : tally_and_finish

	task automatic test_offset;
		op(0, 1, ADDR_RW_OFFSET, 16'h1234);
		op(1, 1, ADDR_RW_OFFSET, 16'hFFFF);
		op(1, 0, ADDR_RW_OFFSET, 16'h0000);
		chk(q, 16'h1234);
		@(posedge ref_clk);
		dgramAddr <= 16'hF000;
		@(posedge ref_clk);
		chk(dgramWrAddr, 16'h0234);
	endtask : test_offset

	task automatic test_status;
		@(posedge ref_clk);
		cfgLoadStrobe <= 1'b1;
		@(posedge ref_clk);
		cfgLoadStrobe <= 1'b0;
		cfgEnhLink <= 1'b0;
		@(posedge ref_clk);
		cfgLoadStrobe <= 1'b1;
		@(posedge ref_clk);
		cfgLoadStrobe <= 1'b0;
		repeat (4) @(posedge ref_clk);
		op(0, 0, ADDR_LINK_STAT, 16'h0000);
		chk(q, 16'hD587);
		@(posedge ref_clk);
		cfgLoaded <= 1'b0;
		hostWdogReloaded <= 1'b0;
		op(1, 0, ADDR_LINK_STAT, 16'h0000);
		chk(q, 16'hD584);
		cfgLoaded <= 1'b1;
	endtask : test_status

	// Loop change requested mid-frame must wait for the frame end
	task automatic test_loop;
		@(posedge ref_clk);
		frameStart <= 4'h1;
		@(posedge ref_clk);
		frameStart <= 4'h0;
		loopSet <= 4'hE;
		repeat (8) @(posedge ref_clk);
		chk(loopClosed, 4'hF);
		repeat (20) @(posedge ref_clk);
		chk(loopClosed, 4'hE);
	endtask : test_loop

	task automatic test_events;
		@(posedge ref_clk);
		linkChangeEvt <= 1'b1;
		appStatChangeEvt <= 1'b1;
		@(posedge ref_clk);
		linkChangeEvt <= 1'b0;
		appStatChangeEvt <= 1'b0;
		op(0, 0, ADDR_LINK_STAT, 16'h0000);
		chk({netEvtAppStat, netEvtLinkStat}, 16'h0002);
		op(0, 0, ADDR_APP_REPORT, 16'h0000);
		chk(netEvtAppStat, 16'h0000);
	endtask : test_events

	task automatic test_mailbox;
		logic [15:0] codes [5] = '{16'h0001, 16'h0002, 16'h0003, 16'h0004, 16'h0008};
		foreach (codes[i])
		begin
			op(0, 1, ADDR_APP_REQ, codes[i]);
			chk(reqState, codes[i]);
			chk(appEvtReq, 16'h0001);
			op(0, 1, ADDR_APP_REQ, codes[i] ^ 16'h0009);
			op(1, 1, ADDR_APP_REQ, 16'h0004);
			chk(reqState, codes[i]);
			op(1, 0, ADDR_APP_REQ + 16'h0001, 16'h0000);
			chk(appEvtReq, 16'h0000);
		end
		writeAckEn <= 1'b1;
		op(0, 1, ADDR_APP_REQ, 16'h0002);
		op(1, 0, ADDR_APP_REQ, 16'h0000);
		chk(appEvtReq, 16'h0001);
		op(1, 1, ADDR_APP_REQ, 16'h0000);
		chk({appEvtReq, reqState[14:0]}, 16'h0002);
		writeAckEn <= 1'b0;
	endtask : test_mailbox

	// Emulation lets writes land back to back and mirrors them into status
	task automatic test_emul;
		@(posedge ref_clk);
		devEmulation <= 1'b1;
		netAcc <= '{1'b1, 1'b0, ADDR_APP_REQ, 16'h0004, 2'b11};
		@(posedge ref_clk);
		netAcc <= '{1'b1, 1'b0, ADDR_APP_REQ, 16'h0008, 2'b11};
		op(1, 1, ADDR_APP_REPORT, 16'h0021);
		op(1, 0, ADDR_APP_REPORT, 16'h0000);
		chk(q, 16'h0008);
		devEmulation <= 1'b0;
		op(1, 1, ADDR_APP_REPORT, 16'h0032);
		op(1, 0, ADDR_APP_REPORT, 16'h0000);
		chk(q, 16'h0032);
	endtask : test_emul

	// Error acknowledge and identification request ride in the control word
	task automatic test_ctl_bits;
		op(0, 1, ADDR_APP_REQ, 16'h0011);
		chk(reqState, 16'h0011);
		op(1, 0, ADDR_APP_REQ, 16'h0000);
		op(0, 1, ADDR_APP_REQ, 16'h0021);
		chk(reqState, 16'h0021);
	endtask : test_ctl_bits

	initial
	begin
		#250000;
		error_cnt++;
		tally_and_finish();
	end

	initial
	begin
		repeat (4) @(posedge ref_clk);
		sys_rst <= 1'b0;
		op(1, 0, ADDR_APP_REPORT, 16'h0000);
		chk(q, RST_APP_REPORT);
		op(0, 0, 16'h0200, 16'h0000);
		chk(q, 16'h0000);
		test_offset();
		test_status();
		test_loop();
		test_events();
		test_mailbox();
		test_emul();
		test_ctl_bits();
		tally_and_finish();
	end
endmodule : tb_top
